// ===== tppu_pkg.sv
// package: register map, reset values and carrier types of the pattern pulse unit
package tppu_pkg;
   localparam int          TPPU_GROUPS        = 4;
   localparam int          TPPU_GW            = 4;
   localparam int          TPPU_LINES         = 16;
   // register byte addresses
   localparam logic [11:0] TPPU_OFS_MODE      = 12'h000;
   localparam logic [11:0] TPPU_OFS_TRIG      = 12'h004;
   localparam logic [11:0] TPPU_OFS_NEXT      = 12'h008;
   localparam logic [11:0] TPPU_OFS_ENABLE    = 12'h00C;
   localparam logic [11:0] TPPU_OFS_DIR       = 12'h010;
   localparam logic [11:0] TPPU_OFS_VALUE     = 12'h014;
   localparam logic [11:0] TPPU_OFS_PIN       = 12'h018;
   // reset values
   localparam logic [7:0]  TPPU_RST_MODE      = 8'hF0;
   localparam logic [3:0]  TPPU_MODE_RSVD     = 4'hF;
   localparam logic [7:0]  TPPU_RST_TRIG      = 8'hFF;
   localparam logic [15:0] TPPU_RST_NEXT      = 16'h0000;
   localparam logic [15:0] TPPU_RST_ENABLE    = 16'h0000;
   localparam logic [15:0] TPPU_RST_DIR       = 16'h0000;
   localparam logic [15:0] TPPU_RST_VALUE     = 16'h0000;
   // trigger select codes
   localparam logic [1:0]  TPPU_SEL_CH0       = 2'h0;
   localparam logic [1:0]  TPPU_SEL_CH1       = 2'h1;
   localparam int          TPPU_TRIG_FW       = 2;

   typedef struct packed {
      logic [2:0] match_a;
      logic [2:0] match_b;
   } tppu_match_t;

   typedef struct packed {
      logic [15:0] out;
      logic [15:0] oe;
   } tppu_pins_t;
endpackage

// ===== tppu_unit.sv
// pattern pulse unit: four timer-triggered 4-bit output groups behind an apb slave
// What this block does
// - mode register selects overlap per group
// - mode register resets to F0
// - upper mode bits ignore writes, read one
// - normal mode updates only at match A
// - non-overlap mode uses matches A and B
// - pattern output needs direction and enable set
// - enabled line first drives current port value
// - selected event copies next data to port
// - enabled input still loads port value, read-only
// - two-bit trigger select per group, resets 11
// - match B copies only zero next bits
`timescale 1ns/1ps
`default_nettype none
module tppu_unit
   import tppu_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire tppu_match_t timer_match,
   input  wire logic [15:0] pin_in,
   output tppu_pins_t       pins
);

   // registers
   logic [3:0]  mode_q;
   logic [7:0]  trig_q;
   logic [15:0] next_q;
   logic [15:0] enable_q;
   logic [15:0] dir_q;
   logic [15:0] value_q;
   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   tppu_pins_t  pins_q;
   // pin synchroniser
   logic [15:0] pin_s1_q;
   logic [15:0] pin_s2_q;

   // apb decode; no wait state, read data still comes from a flop loaded in the setup cycle
   wire         setup_w   = psel && !penable;
   // writes land in the access phase, at the edge where pready is seen
   wire         access_w  = psel && penable && pready_q;
   wire         wr_w      = access_w && pwrite;
   wire         hit_mode  = (paddr == TPPU_OFS_MODE);
   wire         hit_trig  = (paddr == TPPU_OFS_TRIG);
   wire         hit_next  = (paddr == TPPU_OFS_NEXT);
   wire         hit_en    = (paddr == TPPU_OFS_ENABLE);
   wire         hit_dir   = (paddr == TPPU_OFS_DIR);
   wire         hit_val   = (paddr == TPPU_OFS_VALUE);
   wire         hit_pin   = (paddr == TPPU_OFS_PIN);
   wire         hit_any   = hit_mode | hit_trig | hit_next | hit_en | hit_dir
                            | hit_val | hit_pin;
   wire         ro_hit    = hit_pin;
   wire         err_w     = !hit_any || (pwrite && ro_hit);
   wire         wr_mode   = wr_w && hit_mode && pstrb[0];
   wire         wr_trig   = wr_w && hit_trig && pstrb[0];
   wire         wr_next   = wr_w && hit_next;
   wire         wr_en     = wr_w && hit_en;
   wire         wr_dir    = wr_w && hit_dir;
   wire         wr_val    = wr_w && hit_val;
   wire [15:0]  lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   wire [15:0]  wdata_w   = pwdata[15:0];
   // byte lanes merge, so a half write leaves the other byte alone
   wire [15:0]  next_d    = (next_q & ~lane_mask) | (wdata_w & lane_mask);
   wire [15:0]  enable_d  = (enable_q & ~lane_mask) | (wdata_w & lane_mask);
   wire [15:0]  dir_d     = (dir_q & ~lane_mask) | (wdata_w & lane_mask);
   // reserved mode bits have no storage, so writes to them vanish
   wire [3:0]   mode_d    = pwdata[3:0];
   wire [7:0]   trig_d    = pwdata[7:0];
   // enabled lines set to input: the port value is read-only to software
   wire [15:0]  locked_w  = enable_q & ~dir_q;

   // per group trigger decode
   logic [3:0]  fire_a;
   logic [3:0]  fire_b;
   logic [15:0] load_mask;
   logic [15:0] load_d;

   genvar g;
   generate
      for (g = 0; g < TPPU_GROUPS; g = g + 1)
      begin : g_grp
         wire [1:0] sel_w = trig_q[g*TPPU_TRIG_FW +: TPPU_TRIG_FW];
         // codes 10 and 11 both reach channel 2
         wire ma_w = (sel_w == TPPU_SEL_CH0) ? timer_match.match_a[0] :
                     (sel_w == TPPU_SEL_CH1) ? timer_match.match_a[1] :
                                               timer_match.match_a[2];
         wire mb_w = (sel_w == TPPU_SEL_CH0) ? timer_match.match_b[0] :
                     (sel_w == TPPU_SEL_CH1) ? timer_match.match_b[1] :
                                               timer_match.match_b[2];
         wire [3:0] nx_w = next_q[g*TPPU_GW +: TPPU_GW];
         assign fire_a[g] = ma_w;
         // match B ignored unless the group is in non-overlap mode
         wire nov_w = mode_q[g];
         assign fire_b[g] = mb_w && nov_w;
         // match A copies all bits; match B only lets the zeros through
         assign load_mask[g*TPPU_GW +: TPPU_GW] = fire_a[g] ? 4'hF :
                                   fire_b[g] ? ~nx_w : 4'h0;
         assign load_d[g*TPPU_GW +: TPPU_GW] = nx_w;
      end
   endgenerate

   // transfer happens regardless of direction; only enabled lines load
   wire [15:0]  xfer_w    = load_mask & enable_q;
   // enabled input lines hold a port value software cannot overwrite
   wire [15:0]  sw_wmask  = lane_mask & ~locked_w;
   wire [15:0]  value_sw  = (value_q & ~sw_wmask) | (wdata_w & sw_wmask);
   wire [15:0]  value_base = wr_val ? value_sw : value_q;
   // a trigger in the same cycle as a software write wins
   wire [15:0]  value_d   = (value_base & ~xfer_w) | (load_d & xfer_w);

   // pin drive: output value is the port register whether pattern or plain port
   wire [15:0]  out_d     = value_d;
   wire [15:0]  oe_d      = dir_q;

   // read words; unused upper bits read zero, except mode bits 7:4, which read one
   wire [31:0]  rd_mode_w = {24'h000000, TPPU_MODE_RSVD, mode_q};
   wire [31:0]  rd_trig_w = {24'h000000, trig_q};
   wire [31:0]  rd_next_w = {16'h0000, next_q};
   wire [31:0]  rd_en_w   = {16'h0000, enable_q};
   wire [31:0]  rd_dir_w  = {16'h0000, dir_q};
   // input lines read the pad, output lines the port register
   wire [31:0]  rd_val_w  = {16'h0000, (value_q & dir_q) | (pin_s2_q & ~dir_q)};
   wire [31:0]  rd_pin_w  = {16'h0000, pin_s2_q};
   wire [31:0]  rd_w =
      hit_mode ? rd_mode_w :
      hit_trig ? rd_trig_w :
      hit_next ? rd_next_w :
      hit_en   ? rd_en_w :
      hit_dir  ? rd_dir_w :
      hit_val  ? rd_val_w :
      hit_pin  ? rd_pin_w : 32'h00000000;

   // bus response: each answer is a one-cycle pulse from a flop
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready_q <= 1'b0;
      end
      else
      begin
         pready_q <= setup_w;
      end
   end

   // unmapped offsets and writes to the pad register are refused
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pslverr_q <= 1'b0;
      end
      else
      begin
         pslverr_q <= setup_w && err_w;
      end
   end

   // read data is zero outside its access cycle, so stale words never leak
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata_q <= 32'h00000000;
      end
      else
      begin
         prdata_q <= (setup_w && !pwrite) ? rd_w : 32'h00000000;
      end
   end

   // standby does not exist here, only reset restores the mode bits
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= TPPU_RST_MODE[3:0];
      end
      else if (wr_mode)
      begin
         mode_q <= mode_d;
      end
   end

   // two bits per group; codes 10 and 11 both pick channel 2
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         trig_q <= TPPU_RST_TRIG;
      end
      else if (wr_trig)
      begin
         trig_q <= trig_d;
      end
   end

   // the last write before a match is the one that gets copied
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         next_q <= TPPU_RST_NEXT;
      end
      else if (wr_next)
      begin
         next_q <= next_d;
      end
   end

   // a cleared enable bit turns the line back into a plain port
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         enable_q <= TPPU_RST_ENABLE;
      end
      else if (wr_en)
      begin
         enable_q <= enable_d;
      end
   end

   // direction alone decides whether the pad is driven
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         dir_q <= TPPU_RST_DIR;
      end
      else if (wr_dir)
      begin
         dir_q <= dir_d;
      end
   end

   // triggers and software writes merge in value_d every cycle
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         value_q <= TPPU_RST_VALUE;
      end
      else
      begin
         value_q <= value_d;
      end
   end

   // pins take the same next value as the port register: no extra lag
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins_q <= '0;
      end
      else
      begin
         pins_q.out <= out_d;
         pins_q.oe  <= oe_d;
      end
   end

   // first synchroniser stage; nothing but the second stage reads it
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_q <= 16'h0000;
      end
      else
      begin
         pin_s1_q <= pin_in;
      end
   end

   // second stage: the only view of the pads that logic may use
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s2_q <= 16'h0000;
      end
      else
      begin
         pin_s2_q <= pin_s1_q;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign pins    = pins_q;

endmodule
`default_nettype wire

// ===== tppu_assertions.sv
// checker: bus answer and pin timing of the pattern pulse unit
`timescale 1ns/1ps
`default_nettype none
module tppu_chk
   import tppu_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire tppu_match_t timer_match,
   input wire tppu_pins_t  pins
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire su = psel && !penable;
   wire wac = psel && penable && pwrite;
   wire rdm = su && !pwrite && paddr == TPPU_OFS_MODE;
   wire trg = |timer_match;
   setup_ready_a: assert property (su |=> pready) else $error("no ready");
   ready_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
   err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
   idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
   unmapped_error_a: assert property (su && paddr > TPPU_OFS_PIN |=> pslverr) else $error("no error");
   mode_upper_a: assert property (rdm |=> prdata[7:4] == 4'hF)
      else $error("mode upper bits not one");
   out_cause_a: assert property ($changed(pins.out) |-> $past(trg) || $past(wac))
      else $error("output moved without cause");
   oe_cause_a: assert property ($changed(pins.oe) |-> $past(wac, 2))
      else $error("enable moved without write");
   cover property (pslverr);
   cover property ($changed(pins.out));
   cover property (timer_match.match_b != 3'h0);
endmodule
`default_nettype wire

// ===== tppu_timer_model.sv
// timer partner: per request one compare b, then one compare a
`timescale 1ns/1ps
`default_nettype none
module tppu_timer_model
   import tppu_pkg::*;
#(
   parameter int PERIOD = 4,
   parameter int MARGIN = 3
)
(
   input  wire logic       ref_clk,
   input  wire logic       rst_n,
   input  wire logic [2:0] fire,
   output tppu_match_t     match
);
   logic [2:0] live_q;
   logic [7:0] cnt_q;
   // b closes the period, a follows after the margin
   assign match = {(cnt_q == 8'(PERIOD + MARGIN)) ? live_q : 3'h0,
                   (cnt_q == 8'(PERIOD)) ? live_q : 3'h0};
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         {live_q, cnt_q} <= 11'h000;
      else if (fire != 3'h0)
         {live_q, cnt_q} <= {fire, 8'h00};
      else if (cnt_q == 8'(PERIOD + MARGIN))
         {live_q, cnt_q} <= 11'h000;
      else if (live_q != 3'h0)
         cnt_q <= cnt_q + 8'h01;
   end
endmodule
`default_nettype wire

// ===== testbench.sv
// testbench: registers and timer-triggered patterns of the pattern pulse unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tppu_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [2:0]  fire = 3'h0;
   logic [15:0] pin_in = 16'hA5A5;
   tppu_match_t timer_match;
   tppu_pins_t  pins;
   int          n_errors = 0;
   int          n_compared = 0;
   tppu_unit dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .timer_match(timer_match), .pin_in(pin_in),
      .pins(pins));
   tppu_timer_model #(.PERIOD(4), .MARGIN(3)) tmr_u (.ref_clk, .rst_n, .fire, .match(timer_match));
   initial forever #5 ref_clk = ~ref_clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      chk(pslverr, e);
      if (!w)
         chk(prdata, d);
      @(posedge ref_clk);
   endtask
   // mid is seen after compare b, fin after compare a
   task automatic trig(input logic [2:0] ch, input logic [15:0] mid, input logic [15:0] fin);
      fire <= ch;
      @(posedge ref_clk);
      fire <= 3'h0;
      repeat (7) @(posedge ref_clk);
      chk(pins.out, mid);
      repeat (3) @(posedge ref_clk);
      chk(pins.out, fin);
   endtask
   task automatic report_and_stop;
      $display("compared %0d, wrong %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      #20000;
      n_errors++;
      report_and_stop();
   end
   initial
   begin
      logic [15:0] cur;
      logic [15:0] n;
      logic [2:0]  sel;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, TPPU_OFS_MODE, 32'hF0, 1'b0);
      apb(1'b0, TPPU_OFS_TRIG, 32'hFF, 1'b0);
      apb(1'b1, TPPU_OFS_MODE, 32'h05, 1'b0);
      apb(1'b0, TPPU_OFS_MODE, 32'hF5, 1'b0);
      apb(1'b0, 12'h01C, 32'h0, 1'b1);
      apb(1'b1, TPPU_OFS_PIN, 32'h0, 1'b1);
      $display("test registers done");
      apb(1'b1, TPPU_OFS_DIR, 32'h0FFF, 1'b0);
      apb(1'b1, TPPU_OFS_ENABLE, 32'hFF0F, 1'b0);
      apb(1'b1, TPPU_OFS_VALUE, 32'h1234, 1'b0);
      apb(1'b1, TPPU_OFS_NEXT, 32'hCA53, 1'b0);
      chk(pins.out, 16'h0234);
      chk(pins.oe, 16'h0FFF);
      apb(1'b0, TPPU_OFS_VALUE, 32'hA234, 1'b0);
      apb(1'b0, TPPU_OFS_PIN, 32'hA5A5, 1'b0);
      trig(3'h1, 16'h0234, 16'h0234);
      trig(3'h4, 16'h0230, 16'hCA33);
      $display("test non-overlap done");
      cur = 16'hCA33;
      apb(1'b1, TPPU_OFS_MODE, 32'h00, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         sel = 3'h1 << i;
         n = 16'h1111 * 16'(i + 5);
         apb(1'b1, TPPU_OFS_TRIG, {24'h0, {4{2'(i)}}}, 1'b0);
         apb(1'b1, TPPU_OFS_NEXT, {16'h0, n}, 1'b0);
         trig(3'h7 ^ sel, cur, cur);
         trig(sel, cur, (n & 16'hFF0F) | 16'h0030);
         cur = (n & 16'hFF0F) | 16'h0030;
      end
      $display("test trigger select done");
      report_and_stop();
   end
endmodule
bind tppu_unit tppu_chk chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timer_match(timer_match), .pins(pins));
`default_nettype wire
